// >>> hdl/dma_irq_pkg.sv
// Constants shared by the DMA interrupt enable and status/ID block
package dma_irq_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [11:0] CONFIG_OFFSET = 12'h008;
  localparam logic [11:0] ENABLE_OFFSET = 12'h012;
  localparam logic [11:0] VECTOR_OFFSET = 12'h020;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SEL8_BIT = 15;
  localparam int SELLA_BIT = 14;
  localparam int RSV13_BIT = 13;
  localparam int RSV11_BIT = 11;
  localparam int FLAG_BIT = 7;
  localparam int LEVEL_LSB = 0;
  localparam int QUAL_BIT = 11;
  localparam int CMD_BIT = 8;
  localparam int VEC_LSB = 3;

  // ************************************************************
  // Reset and fixed values
  // ************************************************************
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [2:0] VEC_LOW_IACK = 3'h3;
  localparam logic [2:0] VEC_LOW_READ = 3'h0;
  localparam logic [15:0] UNMAPPED_DATA = 16'h0000;

  // ************************************************************
  // Acknowledge cycle sizes
  // ************************************************************
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  typedef enum logic [1:0] {
    IACK_IDLE = 2'b00,
    IACK_ANSWER = 2'b01,
    IACK_WAIT_END = 2'b11
  } iack_state_e;

endpackage

// >>> hdl/status_id_builder.sv
// Registered status/ID word composer for acknowledge cycles
`timescale 1ns/1ps
module status_id_builder (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic sel8,
  input wire logic sel_la,
  input wire logic [4:0] vector_upper_field,
  input wire logic [7:0] logical_addr,
  output logic [15:0] status_id
);

  // ************************************************************
  // Composition
  // ************************************************************
  logic [7:0] vec_byte;
  logic [15:0] word_nxt;
  logic [15:0] status_id_r;

  assign vec_byte = {vector_upper_field, dma_irq_pkg::VEC_LOW_IACK};
  assign word_nxt = !sel8 ? {vec_byte, logical_addr} :
                    sel_la ? {8'h00, logical_addr} :
                    {8'h00, vec_byte};

  always_ff @(posedge clk) begin
    if (srst) begin
      status_id_r <= 16'h0000;
    end else if (load) begin
      status_id_r <= word_nxt;
    end
  end

  assign status_id = status_id_r;

endmodule

// >>> hdl/dma_irq_ctrl.sv
// DMA completion interrupt: enable, configuration, status/ID and acknowledge
//
// Behaviour
// - Writing qualifier 1 and command 1 together enables the DMA interrupt.
// - Writing qualifier 1 and command 0 together disables the DMA interrupt.
// - Qualifier position reads 1 while enabled, 0 while disabled.
// - Hard reset disables the interrupt; soft reset leaves enable state alone.
// - Command bit acts only on writes and always reads back 0.
// - Reserved bits written as 0; reads of them may return anything. The code needs bits 13 and 11 written as 1 before any line is driven.
// - Interrupt is asserted only on backplane request lines.
// - With 8-bit and logical-address selects set, only logical address is returned.
// - 16-bit mode returns vector byte high and logical address low.
// - 16-bit mode places the writable vector field on bits 15 to 11.
// - 8-bit mode without address select places the field on bits 7 to 3.
// - Fixed low bits go to 10..8 in 16-bit, 2..0 in 8-bit mode.
// - Fixed low bits answer 011 on acknowledge, read 000 directly.
// - Writable vector field accepts any value software writes.
// - Hard reset clears the vector field; soft reset leaves it.
// - 8-bit mode answers any size; 16-bit mode ignores 8-bit acknowledges.
// - Condition flag stays set until re-armed; acknowledge releases line only.
// - Three-bit level picks request line 7 down to 1.
`timescale 1ns/1ps
module dma_irq_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic soft_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic dma_irq_cond,
  input wire logic [7:0] logical_addr,
  output logic [7:1] irq_line_out,
  output logic [7:1] irq_line_oe_n,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic [1:0] iack_size,
  output logic iack_ack,
  output logic [15:0] iack_data,
  output logic irq_condition_flag
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Offset match shared by the read and write decodes
  function automatic logic addr_hit(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    addr_hit = (addr == offset);
  endfunction

  // Byte lane 1 holds bits 15..8, lane 0 holds bits 7..0
  function automatic logic lane_hit(
    input logic wr,
    input logic [11:0] addr,
    input logic [11:0] offset,
    input logic be
  );
    lane_hit = wr && addr_hit(addr, offset) && be;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic enable_r;
  logic enable_nxt;
  logic sel8_r;
  logic sel8_nxt;
  logic sel_la_r;
  logic sel_la_nxt;
  logic rsv13_r;
  logic rsv13_nxt;
  logic rsv11_r;
  logic rsv11_nxt;
  logic [2:0] level_r;
  logic [2:0] level_nxt;
  logic [4:0] vec_r;
  logic [4:0] vec_nxt;
  logic flag_r;
  logic flag_nxt;
  logic acked_r;
  logic acked_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  dma_irq_pkg::iack_state_e state_r;
  dma_irq_pkg::iack_state_e state_nxt;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Acknowledge signals come off the backplane, so they are retimed first
  logic iack_req_m_r;
  logic iack_req_s_r;
  logic [2:0] iack_level_m_r;
  logic [2:0] iack_level_s_r;
  logic [1:0] iack_size_m_r;
  logic [1:0] iack_size_s_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      iack_req_m_r <= 1'b0;
      iack_req_s_r <= 1'b0;
      iack_level_m_r <= 3'h0;
      iack_level_s_r <= 3'h0;
      iack_size_m_r <= 2'h0;
      iack_size_s_r <= 2'h0;
    end else begin
      iack_req_m_r <= iack_req;
      iack_req_s_r <= iack_req_m_r;
      iack_level_m_r <= iack_level;
      iack_level_s_r <= iack_level_m_r;
      iack_size_m_r <= iack_size;
      iack_size_s_r <= iack_size_m_r;
    end
  end

  // ************************************************************
  // Acknowledge input qualification
  // ************************************************************
  // Level and size bits can skew against the request across the crossing,
  // so the word is only trusted once two samples agree
  logic iack_req_q_r;
  logic [2:0] iack_level_q_r;
  logic [1:0] iack_size_q_r;
  logic iack_settled;

  always_ff @(posedge clk) begin
    if (srst) begin
      iack_req_q_r <= 1'b0;
      iack_level_q_r <= 3'h0;
      iack_size_q_r <= 2'h0;
    end else begin
      iack_req_q_r <= iack_req_s_r;
      iack_level_q_r <= iack_level_s_r;
      iack_size_q_r <= iack_size_s_r;
    end
  end

  assign iack_settled = iack_req_s_r && iack_req_q_r &&
                        (iack_level_s_r == iack_level_q_r) && (iack_size_s_r == iack_size_q_r);

  // ************************************************************
  // Register write decode
  // ************************************************************
  logic cfg_hi_wr;
  logic cfg_lo_wr;
  logic en_hi_wr;
  logic vec_lo_wr;
  logic qual_set;

  assign cfg_hi_wr = lane_hit(reg_wr, reg_addr, dma_irq_pkg::CONFIG_OFFSET, reg_be[1]);
  assign cfg_lo_wr = lane_hit(reg_wr, reg_addr, dma_irq_pkg::CONFIG_OFFSET, reg_be[0]);
  assign en_hi_wr = lane_hit(reg_wr, reg_addr, dma_irq_pkg::ENABLE_OFFSET, reg_be[1]);
  assign vec_lo_wr = lane_hit(reg_wr, reg_addr, dma_irq_pkg::VECTOR_OFFSET, reg_be[0]);
  // A write without the qualifier leaves the enable state untouched
  assign qual_set = reg_wdata[dma_irq_pkg::QUAL_BIT];

  assign enable_nxt = (en_hi_wr && qual_set) ? reg_wdata[dma_irq_pkg::CMD_BIT] : enable_r;
  assign sel8_nxt = cfg_hi_wr ? reg_wdata[dma_irq_pkg::SEL8_BIT] : sel8_r;
  assign sel_la_nxt = cfg_hi_wr ? reg_wdata[dma_irq_pkg::SELLA_BIT] : sel_la_r;
  assign rsv13_nxt = cfg_hi_wr ? reg_wdata[dma_irq_pkg::RSV13_BIT] : rsv13_r;
  assign rsv11_nxt = cfg_hi_wr ? reg_wdata[dma_irq_pkg::RSV11_BIT] : rsv11_r;
  assign level_nxt = cfg_lo_wr ? reg_wdata[dma_irq_pkg::LEVEL_LSB +: 3] : level_r;
  assign vec_nxt = vec_lo_wr ? reg_wdata[dma_irq_pkg::VEC_LSB +: 5] : vec_r;

  // ************************************************************
  // Register read decode
  // ************************************************************
  logic [15:0] cfg_view;
  logic [15:0] en_view;
  logic [15:0] vec_view;
  logic hit_cfg;
  logic hit_en;
  logic hit_vec;

  assign hit_cfg = addr_hit(reg_addr, dma_irq_pkg::CONFIG_OFFSET);
  assign hit_en = addr_hit(reg_addr, dma_irq_pkg::ENABLE_OFFSET);
  assign hit_vec = addr_hit(reg_addr, dma_irq_pkg::VECTOR_OFFSET);

  // Unused bits read as zero; reserved bits 13 and 11 read back as written
  assign cfg_view = {sel8_r, sel_la_r, rsv13_r, 1'b0, rsv11_r, 3'h0,
                     flag_r, 4'h0, level_r};
  assign en_view = {4'h0, enable_r, 2'h0, 1'b0, 8'h00};
  assign vec_view = {8'h00, vec_r, dma_irq_pkg::VEC_LOW_READ};

  always_comb begin
    if (!reg_rd) begin
      rdata_nxt = rdata_r;
    end else if (hit_cfg) begin
      rdata_nxt = cfg_view;
    end else if (hit_en) begin
      rdata_nxt = en_view;
    end else if (hit_vec) begin
      rdata_nxt = vec_view;
    end else begin
      rdata_nxt = dma_irq_pkg::UNMAPPED_DATA;
    end
  end

  // Every access, mapped or not, is answered one cycle later
  assign ack_nxt = reg_wr || reg_rd;

  // ************************************************************
  // Interrupt condition and request line
  // ************************************************************
  logic ints_ready;
  logic line_active;
  logic [7:1] line_sel;

  // The level field is only meaningful with both reserved set-up bits written
  assign ints_ready = rsv13_r && rsv11_r && (level_r != 3'h0);

  // Condition latches and is dropped only once channel logic removes it
  // while the interrupt is disabled, which is the re-arm window
  assign flag_nxt = dma_irq_cond || (flag_r && enable_r);
  // Release after acknowledge holds until software disables the interrupt
  assign acked_nxt = (state_r == dma_irq_pkg::IACK_ANSWER) || (acked_r && enable_r);

  assign line_active = enable_r && flag_r && !acked_r && ints_ready;

  genvar lv;
  generate
    for (lv = 1; lv <= 7; lv++) begin : g_line
      assign line_sel[lv] = line_active && (level_r == 3'(lv));
      assign irq_line_out[lv] = 1'b0;
      assign irq_line_oe_n[lv] = !line_sel[lv];
    end
  endgenerate

  // ************************************************************
  // Acknowledge sequencer
  // ************************************************************
  logic level_match;
  logic size_ok;
  logic answer_go;

  assign level_match = (iack_level_s_r == level_r);
  assign size_ok = sel8_r || (iack_size_s_r == dma_irq_pkg::SIZE_16) ||
                   (iack_size_s_r == dma_irq_pkg::SIZE_32);
  // A refused size never answers, so the handler runs into its own timeout
  assign answer_go = iack_settled && level_match && line_active && size_ok;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dma_irq_pkg::IACK_IDLE: begin
        if (answer_go) begin
          state_nxt = dma_irq_pkg::IACK_ANSWER;
        end
      end
      dma_irq_pkg::IACK_ANSWER: begin
        state_nxt = dma_irq_pkg::IACK_WAIT_END;
      end
      dma_irq_pkg::IACK_WAIT_END: begin
        if (!iack_req_s_r) begin
          state_nxt = dma_irq_pkg::IACK_IDLE;
        end
      end
      default: begin
        state_nxt = dma_irq_pkg::IACK_IDLE;
      end
    endcase
    // Soft reset only abandons a cycle in flight, never the settings
    if (soft_rst) begin
      state_nxt = dma_irq_pkg::IACK_IDLE;
    end
  end

  status_id_builder u_builder (
    .clk(clk),
    .srst(srst),
    .load(answer_go),
    .sel8(sel8_r),
    .sel_la(sel_la_r),
    .vector_upper_field(vec_r),
    .logical_addr(logical_addr),
    .status_id(iack_data)
  );

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      enable_r <= 1'b0;
      sel8_r <= 1'b0;
      sel_la_r <= 1'b0;
      rsv13_r <= 1'b0;
      rsv11_r <= 1'b0;
      level_r <= dma_irq_pkg::LEVEL_RESET;
      vec_r <= dma_irq_pkg::VEC_RESET;
    end else begin
      enable_r <= enable_nxt;
      sel8_r <= sel8_nxt;
      sel_la_r <= sel_la_nxt;
      rsv13_r <= rsv13_nxt;
      rsv11_r <= rsv11_nxt;
      level_r <= level_nxt;
      vec_r <= vec_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_r <= 1'b0;
      acked_r <= 1'b0;
      state_r <= dma_irq_pkg::IACK_IDLE;
    end else begin
      flag_r <= flag_nxt;
      acked_r <= acked_nxt;
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata = rdata_r;
  assign reg_ack = ack_r;
  assign iack_ack = (state_r == dma_irq_pkg::IACK_ANSWER);
  assign irq_condition_flag = flag_r;

endmodule

// >>> verification/dma_irq_ctrl_sva.sv
// Concurrent checks on the DMA interrupt block ports
`timescale 1ns/1ps
module dma_irq_ctrl_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic [7:1] irq_line_out,
  input wire logic [7:1] irq_line_oe_n,
  input wire logic iack_req,
  input wire logic iack_ack,
  input wire logic [15:0] iack_data,
  input wire logic irq_condition_flag
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire line_on = irq_line_oe_n != 7'h7f;
  // Answer drops the line but keeps the flag
  sequence s_ack_free;
    iack_ack ##1 (!line_on && irq_condition_flag);
  endsequence
  a_reg_ack_next:
    assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("reg_ack missing");
  a_cmd_reads_zero:
    assert property (reg_ack && $past(reg_rd && reg_addr == dma_irq_pkg::ENABLE_OFFSET)
      |-> (reg_rdata & 16'hf7ff) == 16'h0000) else $error("enable read bits not zero");
  a_vec_low_zero:
    assert property (reg_ack && $past(reg_rd && reg_addr == dma_irq_pkg::VECTOR_OFFSET)
      |-> reg_rdata[2:0] == 3'h0) else $error("vector low bits not zero on read");
  a_line_open_drain:
    assert property (irq_line_out == 7'h00) else $error("request line value not low");
  a_one_line:
    assert property ($onehot0(~irq_line_oe_n)) else $error("more than one line driven");
  a_line_needs_flag:
    assert property (line_on |-> irq_condition_flag) else $error("line driven without flag");
  a_ack_releases:
    assert property (iack_ack |-> s_ack_free) else $error("line kept or flag lost after ack");
  a_ack_from_req:
    assert property (iack_ack |-> $past(iack_req, 4)) else $error("ack without request");
  a_iack_mid_bits:
    assert property (iack_ack && iack_data[15:8] != 8'h00 |-> iack_data[10:8] == 3'h3)
      else $error("fixed vector bits wrong");
endmodule
bind dma_irq_ctrl dma_irq_ctrl_sva u_sva (.clk(clk), .srst(srst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .irq_line_out(irq_line_out), .irq_line_oe_n(irq_line_oe_n), .iack_req(iack_req),
  .iack_ack(iack_ack), .iack_data(iack_data), .irq_condition_flag(irq_condition_flag));

// >>> verification/iack_handler_model.sv
// Behavioural backplane acknowledge handler
`timescale 1ns/1ps
module iack_handler_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] lvl,
  input wire logic [1:0] size,
  input wire logic [3:0] hold,
  output logic iack_req,
  output logic [2:0] iack_level,
  output logic [1:0] iack_size
);
  // ****
  // Cycle driver
  // ****
  logic [3:0] cnt_r;
  initial begin
    {iack_req, iack_level, iack_size, cnt_r} = '0;
  end
  // Idle level and size toggle so a stale value never looks live
  always @(negedge clk) begin
    if (iack_req) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == hold) begin
        iack_req <= 1'b0;
      end
    end else if (go) begin
      iack_req <= 1'b1;
      iack_level <= lvl;
      iack_size <= size;
      cnt_r <= 4'h0;
    end else begin
      iack_level <= ~iack_level;
      iack_size <= ~iack_size;
    end
  end
endmodule

// >>> verification/dma_irq_ctrl_tb.sv
// Self-checking bench for the DMA interrupt block
`timescale 1ns/1ps
module dma_irq_ctrl_tb;
  // ****
  // Signals and instances
  // ****
  logic clk, srst, soft_rst, reg_wr, reg_rd, dma_irq_cond, go, reg_ack, iack_req;
  logic iack_ack, irq_condition_flag, rd_d, s8, sla;
  logic [11:0] reg_addr;
  logic [1:0] reg_be, iack_size, sz;
  logic [15:0] reg_wdata, reg_rdata, iack_data, e, ln;
  logic [7:0] logical_addr;
  logic [7:1] irq_line_out, irq_line_oe_n;
  logic [2:0] iack_level, lv;
  logic [4:0] v;
  logic [3:0] hold;
  logic [15:0] rq[$], iq[$];
  int num_errors = 0, n_compared = 0, n_ack = 0, exp_ack = 0, seed, m, r;
  dma_irq_ctrl DUT (.clk(clk), .srst(srst), .soft_rst(soft_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .dma_irq_cond(dma_irq_cond),
    .logical_addr(logical_addr), .irq_line_out(irq_line_out), .irq_line_oe_n(irq_line_oe_n),
    .iack_req(iack_req), .iack_level(iack_level), .iack_size(iack_size),
    .iack_ack(iack_ack), .iack_data(iack_data), .irq_condition_flag(irq_condition_flag));
  iack_handler_model handler (.clk(clk), .go(go), .lvl(lv), .size(sz), .hold(hold),
    .iack_req(iack_req), .iack_level(iack_level), .iack_size(iack_size));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    n_compared++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // One-cycle strobe with an idle cycle after, so strobes never merge
  task automatic acc(input logic w, input logic [11:0] a, input logic [1:0] b,
      input logic [15:0] d);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = {w, !w, a, b, d};
    @(negedge clk);
    {reg_wr, reg_rd} = 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] x);
    rq.push_back(x);
    acc(1'b0, a, 2'b11, 16'h0000);
  endtask
  task automatic give_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****
  // Result watcher
  // ****
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (reg_ack === 1'b1 && rd_d === 1'b1 && rq.size() > 0) begin
      chk("reg_rdata", reg_rdata, rq.pop_front());
    end
    if (iack_ack === 1'b1) begin
      n_ack++;
      if (iq.size() > 0) begin
        chk("iack_data", iack_data, iq.pop_front());
      end
    end
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 32'h5bd5;
    {srst, soft_rst, reg_wr, reg_rd, dma_irq_cond, go} = 6'b100000;
    {reg_addr, reg_be, reg_wdata, lv, sz, hold} = '0;
    logical_addr = 8'($random(seed));
    repeat (5) @(negedge clk);
    srst = 1'b0;
    rd(dma_irq_pkg::ENABLE_OFFSET, 16'h0000);
    rd(dma_irq_pkg::VECTOR_OFFSET, 16'h0000);
    acc(1'b1, dma_irq_pkg::ENABLE_OFFSET, 2'b11, 16'h0100);
    rd(dma_irq_pkg::ENABLE_OFFSET, 16'h0000);
    acc(1'b1, dma_irq_pkg::ENABLE_OFFSET, 2'b10, 16'h0900);
    rd(dma_irq_pkg::ENABLE_OFFSET, 16'h0800);
    acc(1'b1, 12'h3fe, 2'b11, 16'hffff);
    rd(12'h3fe, dma_irq_pkg::UNMAPPED_DATA);
    repeat (3) begin
      v = 5'($random(seed));
      acc(1'b1, dma_irq_pkg::VECTOR_OFFSET, 2'b01, {8'h00, v, 3'b000});
      rd(dma_irq_pkg::VECTOR_OFFSET, {8'h00, v, 3'b000});
    end
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    rd(dma_irq_pkg::ENABLE_OFFSET, 16'h0800);
    rd(dma_irq_pkg::VECTOR_OFFSET, {8'h00, v, 3'b000});
    acc(1'b1, dma_irq_pkg::ENABLE_OFFSET, 2'b10, 16'h0800);
    rd(dma_irq_pkg::ENABLE_OFFSET, 16'h0000);
    for (int i = 1; i < 8; i++) begin
      m = i % 4;
      s8 = m > 1;
      sla = m == 3;
      r = $random(seed);
      sz = (m == 1) ? dma_irq_pkg::SIZE_8 : (m == 3) ? dma_irq_pkg::SIZE_32 :
           r[0] ? dma_irq_pkg::SIZE_16 : (m == 0) ? dma_irq_pkg::SIZE_32 : dma_irq_pkg::SIZE_8;
      lv = 3'(i);
      v = 5'($random(seed));
      hold = 4'h4 + 4'($random(seed) & 3);
      e = s8 ? (sla ? {8'h00, logical_addr} : {8'h00, v, 3'h3}) : {v, 3'h3, logical_addr};
      ln = {9'h000, ~(7'h01 << (i - 1))};
      acc(1'b1, dma_irq_pkg::VECTOR_OFFSET, 2'b01, {8'h00, v, 3'b000});
      acc(1'b1, dma_irq_pkg::CONFIG_OFFSET, 2'b11, {s8, sla, 3'b101, 8'h00, lv});
      dma_irq_cond = 1'b1;
      repeat (2) @(negedge clk);
      chk("line_idle", {9'h000, irq_line_oe_n}, 16'h007f);
      acc(1'b1, dma_irq_pkg::ENABLE_OFFSET, 2'b10, 16'h0900);
      dma_irq_cond = 1'b0;
      chk("line_on", {9'h000, irq_line_oe_n}, ln);
      rd(dma_irq_pkg::CONFIG_OFFSET, {s8, sla, 3'b101, 3'h0, 1'b1, 4'h0, lv});
      if (m != 1) begin
        iq.push_back(e);
        exp_ack++;
      end
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      repeat (12) @(negedge clk);
      chk("flag_kept", {15'h0000, irq_condition_flag}, 16'h0001);
      chk("line_after", {9'h000, irq_line_oe_n}, (m == 1) ? ln : 16'h007f);
      acc(1'b1, dma_irq_pkg::ENABLE_OFFSET, 2'b10, 16'h0800);
      repeat (2) @(negedge clk);
      chk("flag_clr", {15'h0000, irq_condition_flag}, 16'h0000);
    end
    repeat (4) @(negedge clk);
    chk("ack_count", n_ack[15:0], exp_ack[15:0]);
    give_verdict();
  end
endmodule
